// ==== include/wtw_pkg.sv ====
// Shared constants and carrier types of the wake-up timer watchdog
package wtw_pkg;

  // Clock period and the one-millisecond time base derived from it
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;

  // Widths of the millisecond phase counter and of the interval code
  localparam int MS_W = 23;
  localparam int CODE_W = 17;

  // Interval code unit: one code step is 100 ms
  localparam logic [MS_W-1:0] CODE_UNIT_MS = 23'h000064;
  // Code used when measurement times out without a result
  localparam logic [CODE_W-1:0] CODE_DEFAULT = 17'h00001;

  // Times in milliseconds
  localparam logic [MS_W-1:0] RESET_PULSE_MS = 23'h000140;
  localparam logic [MS_W-1:0] ACK_LEAD_MS = 23'h000014;
  localparam logic [MS_W-1:0] MEASURE_MAX_MS = 23'h000078;
  localparam logic [4:0] ALERT_PULSE_MS = 5'h14;
  localparam logic [4:0] MANUAL_VALID_MS = 5'h14;
  localparam logic [4:0] MANUAL_WINDOW_MS = 5'h1e;
  localparam logic [4:0] DEBOUNCE_MS = 5'h14;

  // Result handed over by the measurement stage
  typedef struct packed {
    logic valid;
    logic [CODE_W-1:0] code;
  } wtw_meas_t;

endpackage

// ==== hw/wtw_mrst_filter.sv ====
// Manual-reset pin synchroniser and glitch filter on a 1 ms time base
module wtw_mrst_filter (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic pin_i,
  input wire logic tick_i,
  input wire logic enable_i,
  output logic level_o,
  output logic active_o
);

  //////////////////////////////////////////////////////////////////////////
  // Synchroniser: the pin is asynchronous to our clock
  logic pin_s1_reg; // First stage, read only by the second
  logic pin_s2_reg; // Safe level

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
    end else begin
      pin_s1_reg <= pin_i;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  assign level_o = pin_s2_reg;

  //////////////////////////////////////////////////////////////////////////
  // Observation window and counters, all in milliseconds
  logic [4:0] win_reg; // Ms elapsed in the window, 0 = no window
  logic [4:0] high_reg; // High samples seen in the window
  logic [4:0] low_reg; // Consecutive low samples while active
  logic active_reg; // Valid manual reset held

  // A window opens on the first high sample; 20 high ms out of 30
  // validate, so short glitches die when the window closes
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      win_reg <= 5'h00;
      high_reg <= 5'h00;
      low_reg <= 5'h00;
      active_reg <= 1'b0;
    end else if (!enable_i) begin
      // Pin belongs to the analog path: detector held idle
      win_reg <= 5'h00;
      high_reg <= 5'h00;
      low_reg <= 5'h00;
      active_reg <= 1'b0;
    end else if (tick_i) begin
      if (active_reg) begin
        // Release only after a full debounce time of low level
        if (pin_s2_reg) begin
          low_reg <= 5'h00;
        end else if (low_reg == wtw_pkg::DEBOUNCE_MS - 5'h01) begin
          active_reg <= 1'b0;
          low_reg <= 5'h00;
        end else begin
          low_reg <= low_reg + 5'h01;
        end
      end else if (win_reg == 5'h00) begin
        // Idle: open a window on a high sample
        if (pin_s2_reg) begin
          win_reg <= 5'h01;
          high_reg <= 5'h01;
        end
      end else if (pin_s2_reg &&
                   high_reg == wtw_pkg::MANUAL_VALID_MS - 5'h01) begin
        active_reg <= 1'b1;
        win_reg <= 5'h00;
        high_reg <= 5'h00;
      end else if (win_reg == wtw_pkg::MANUAL_WINDOW_MS - 5'h01) begin
        // Window over without enough high time: a glitch
        win_reg <= 5'h00;
        high_reg <= 5'h00;
      end else begin
        win_reg <= win_reg + 5'h01;
        high_reg <= high_reg + {4'h0, pin_s2_reg};
      end
    end
  end

  assign active_o = active_reg;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  a_valid_needs_high: assert property (
    @(posedge clock_i) disable iff (rst_i)
    $rose(active_reg) |->
      $past(high_reg) == wtw_pkg::MANUAL_VALID_MS - 5'h01
      && $past(tick_i) && $past(pin_s2_reg))
    else $error("manual reset validated without 20 ms high");

  a_release_debounce: assert property (
    @(posedge clock_i) disable iff (rst_i)
    $fell(active_reg) && $past(enable_i) |->
      $past(low_reg) == wtw_pkg::DEBOUNCE_MS - 5'h01 &&
      !$past(pin_s2_reg))
    else $error("manual reset released before debounce time");

endmodule

// ==== hw/wtw_core.sv ====
// Wake-up timer watchdog: wake pulses, acknowledge watch, host reset
//
// Functional notes
// - Periodic wake pulses, period 100ms to 7200s
// - Missed acknowledge pulls host reset low
// - No wake first interval or after miss
// - Wake output low when not pulsing
// - Only first rising acknowledge edge counts
// - Acknowledge clears watchdog, not interval counter
// - Acknowledge during wake ends wake at once
// - Host reset low during power-on and measurement
// - Pin seen high one cycle during measurement aborts it
// - Measure interval resistor once per power-on
// - Host reset restarts the interval counters
// - Reset edge spacing is interval plus pulse
// - Manual reset aborts and restarts measurement
// - Manual reset needs 20ms in 30ms window
// - Manual reset clears counters until release
// - Host reset held through manual reset, debounce
// - Manual reset forces wake low, reset low
// - Pin goes to digital detect after measuring
// - Measurement finishes within 120ms
module wtw_core #(
  parameter int TICK_CYC = wtw_pkg::TICK_CYC
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ack_i,
  input wire logic mrst_pin_i,
  input wire wtw_pkg::wtw_meas_t meas_i,
  output logic meas_en_o,
  output logic wake_o,
  output logic host_reset_low_out_o
);

  //////////////////////////////////////////////////////////////////////////
  // Declarations
  typedef enum logic [2:0] {
    ST_MEASURE, // Resistor measurement running
    ST_MHOLD, // Measurement aborted, pin held high
    ST_RESET, // Host reset pulse
    ST_RUN, // Normal interval counting
    ST_MRST // Valid manual reset held
  } wtw_state_t;

  wtw_state_t state_reg; // Current mode
  wtw_state_t state_next; // Mode for the next cycle
  logic [16:0] tick_cnt_reg; // Cycle prescaler for the 1 ms tick
  logic tick; // One-cycle pulse each millisecond
  logic [wtw_pkg::MS_W-1:0] phase_reg; // Ms elapsed in current phase
  logic [wtw_pkg::MS_W-1:0] interval_reg; // Programmed interval, ms
  logic set_reg; // Interval has been measured
  logic ack_s1_reg; // Acknowledge synchroniser, first stage
  logic ack_s2_reg; // Acknowledge synchroniser, second stage
  logic ack_s3_reg; // Previous synchronised level
  logic ack_rise; // Rising acknowledge edge
  logic ack_take; // First edge in the current interval
  logic ack_seen_reg; // Watchdog: interval already acknowledged
  logic miss_reg; // Deadline passed without acknowledge
  logic wrap; // Last cycle of an interval in normal mode
  logic deadline; // Acknowledge deadline reached
  logic meas_end; // Measurement result or timeout
  logic [4:0] wake_ms_reg; // Ms the wake pulse has lasted
  logic wake_reg; // Wake output register
  logic host_rst_n_reg; // Host reset output register
  logic meas_en_reg; // Analog path enable register
  logic pin_level; // Synchronised shared pin level
  logic mrst_active; // Valid manual reset in force

  //////////////////////////////////////////////////////////////////////////
  // Manual-reset filter; digital detect only once interval is set
  wtw_mrst_filter u_mrst (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .pin_i(mrst_pin_i),
    .tick_i(tick),
    .enable_i(set_reg),
    .level_o(pin_level),
    .active_o(mrst_active)
  );

  //////////////////////////////////////////////////////////////////////////
  // Millisecond time base; pulse widths count these ticks
  assign tick = tick_cnt_reg == 17'(TICK_CYC - 1);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_reg <= 17'h00000;
    end else if (tick) begin
      tick_cnt_reg <= 17'h00000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 17'h00001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Acknowledge synchroniser and edge detector on the second stage
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
      ack_s3_reg <= 1'b0;
    end else begin
      ack_s1_reg <= ack_i;
      ack_s2_reg <= ack_s1_reg;
      ack_s3_reg <= ack_s2_reg;
    end
  end

  // Levels are ignored; only a low-to-high change is an acknowledge
  assign ack_rise = ack_s2_reg && !ack_s3_reg;
  assign ack_take = ack_rise && !ack_seen_reg &&
                    state_reg == ST_RUN;

  //////////////////////////////////////////////////////////////////////////
  // Phase events
  assign wrap = state_reg == ST_RUN && tick &&
                phase_reg == interval_reg - 23'h000001;
  assign deadline = state_reg == ST_RUN && tick && phase_reg ==
                    interval_reg - wtw_pkg::ACK_LEAD_MS - 23'h000001;
  assign meas_end = meas_i.valid || (tick &&
                    phase_reg == wtw_pkg::MEASURE_MAX_MS - 23'h000001);

  //////////////////////////////////////////////////////////////////////////
  // Mode sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_MEASURE: begin
        if (pin_level) begin
          state_next = ST_MHOLD;
        end else if (meas_end) begin
          state_next = ST_RESET;
        end
      end
      ST_MHOLD: begin
        // Restart the measurement once the switch is released
        if (!pin_level) begin
          state_next = ST_MEASURE;
        end
      end
      ST_RESET: begin
        if (mrst_active) begin
          state_next = ST_MRST;
        end else if (tick && phase_reg ==
                     wtw_pkg::RESET_PULSE_MS - 23'h000001) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (mrst_active) begin
          state_next = ST_MRST;
        end else if (wrap && miss_reg) begin
          state_next = ST_RESET;
        end
      end
      ST_MRST: begin
        // Released pin plus debounce, then one more reset pulse
        if (!mrst_active) begin
          state_next = ST_RESET;
        end
      end
      default: begin
        state_next = ST_MEASURE;
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_MEASURE;
    end else begin
      state_reg <= state_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Phase counter, cleared on every mode change and each interval
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      phase_reg <= '0;
    end else if (state_next != state_reg || wrap) begin
      phase_reg <= '0;
    end else if (state_reg == ST_MRST || state_reg == ST_MHOLD) begin
      phase_reg <= '0;
    end else if (tick) begin
      phase_reg <= phase_reg + 23'h000001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interval capture: once per power-on, never rewritten
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      interval_reg <= wtw_pkg::CODE_UNIT_MS;
      set_reg <= 1'b0;
    end else if (state_reg == ST_MEASURE && !set_reg &&
                 !pin_level && meas_end) begin
      set_reg <= 1'b1;
      // A zero code or a timeout falls back to the shortest period
      if (meas_i.valid && meas_i.code != '0) begin
        interval_reg <= 23'({6'h00, meas_i.code} *
                            wtw_pkg::CODE_UNIT_MS);
      end else begin
        interval_reg <= 23'({6'h00, wtw_pkg::CODE_DEFAULT} *
                            wtw_pkg::CODE_UNIT_MS);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Watchdog: acknowledge flag and deadline verdict
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ack_seen_reg <= 1'b0;
    end else if (state_reg != ST_RUN) begin
      ack_seen_reg <= 1'b0;
    end else if (ack_rise && wrap) begin
      // Edge in the closing cycle counts for the new interval
      ack_seen_reg <= 1'b1;
    end else if (wrap) begin
      ack_seen_reg <= 1'b0;
    end else if (ack_take) begin
      ack_seen_reg <= 1'b1;
    end
  end

  // Sampled 20 ms before the interval ends; a late edge cannot save it
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      miss_reg <= 1'b0;
    end else if (state_reg != ST_RUN || wrap) begin
      miss_reg <= 1'b0;
    end else if (deadline) begin
      miss_reg <= !(ack_seen_reg || ack_take);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Wake pulse: starts each interval after an acknowledged one
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wake_reg <= 1'b0;
      wake_ms_reg <= 5'h00;
    end else if (state_next != ST_RUN) begin
      wake_reg <= 1'b0;
      wake_ms_reg <= 5'h00;
    end else if (wrap) begin
      // Entering normal mode is not a wrap, so no first-cycle wake
      wake_reg <= !miss_reg;
      wake_ms_reg <= 5'h00;
    end else if (ack_take) begin
      wake_reg <= 1'b0;
    end else if (wake_reg && tick) begin
      if (wake_ms_reg == wtw_pkg::ALERT_PULSE_MS - 5'h01) begin
        wake_reg <= 1'b0;
      end else begin
        wake_ms_reg <= wake_ms_reg + 5'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Host reset and analog enable follow the next mode directly
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      host_rst_n_reg <= 1'b0;
      meas_en_reg <= 1'b0;
    end else begin
      host_rst_n_reg <= state_next == ST_RUN;
      meas_en_reg <= state_next == ST_MEASURE;
    end
  end

  assign wake_o = wake_reg;
  assign host_reset_low_out_o = host_rst_n_reg;
  assign meas_en_o = meas_en_reg;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  a_wake_idle_low: assert property (
    @(posedge clock_i) disable iff (rst_i)
    state_reg != ST_RUN |-> !wake_o)
    else $error("wake high outside normal mode");

  a_reset_during_meas: assert property (
    @(posedge clock_i) disable iff (rst_i)
    state_reg inside {ST_MEASURE, ST_MHOLD} |->
      !host_reset_low_out_o)
    else $error("host reset released during measurement");

  a_ack_ends_wake: assert property (
    @(posedge clock_i) disable iff (rst_i)
    ack_take && wake_o && !wrap |=> !wake_o)
    else $error("wake not ended by acknowledge");

  a_wake_cause: assert property (
    @(posedge clock_i) disable iff (rst_i)
    $rose(wake_o) |-> $past(wrap) && !$past(miss_reg))
    else $error("wake rose without acknowledged interval");

  a_miss_reset: assert property (
    @(posedge clock_i) disable iff (rst_i)
    wrap && miss_reg && !mrst_active |=>
      !host_reset_low_out_o && phase_reg == '0 && !wake_o)
    else $error("missed acknowledge did not reset host");

  a_interval_held: assert property (
    @(posedge clock_i) disable iff (rst_i)
    set_reg |=> set_reg && $stable(interval_reg))
    else $error("interval changed after capture");

  a_reset_width: assert property (
    @(posedge clock_i) disable iff (rst_i)
    $rose(host_reset_low_out_o) |-> $past(state_reg) == ST_RESET &&
      $past(phase_reg) == wtw_pkg::RESET_PULSE_MS - 23'h000001)
    else $error("host reset pulse width wrong");

  a_manual_forces: assert property (
    @(posedge clock_i) disable iff (rst_i)
    mrst_active |=> !host_reset_low_out_o && !wake_o)
    else $error("manual reset did not force outputs");

  a_abort_measure: assert property (
    @(posedge clock_i) disable iff (rst_i)
    state_reg == ST_MEASURE && pin_level |=>
      !meas_en_o && !set_reg ##1 !meas_en_o || !pin_level)
    else $error("measurement not aborted by manual reset");

  a_ack_keeps_phase: assert property (
    @(posedge clock_i) disable iff (rst_i)
    ack_take && !tick && state_next == ST_RUN |=>
      $stable(phase_reg))
    else $error("acknowledge disturbed the interval counter");

endmodule

// ==== test/wtw_host_model.sv ====
// Behavioural host controller that answers wake pulses with an acknowledge
module wtw_host_model (
  input wire logic clock_i,
  input wire logic wake_i,
  input wire logic host_reset_low_i,
  input wire logic [15:0] delay_i,
  output logic ack_o
);
  timeunit 1ns;
  timeprecision 1ns;

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic wake_q = 1'h0; // Wake level seen at the previous edge
  logic rst_q = 1'h0; // Host reset level seen at the previous edge
  int cnt = 0; // Cycles since the last wake or reset release
  bit armed = 1'h0; // An acknowledge is still owed

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge after a programmable delay; a delay of 0 never answers
  // Delays below 10 cycles would break the 100 ns gap, so callers avoid them
  always @(posedge clock_i) begin
    wake_q <= wake_i;
    rst_q <= host_reset_low_i;
    if (host_reset_low_i !== 1'h1) begin
      // Held in reset: the controller is quiet
      armed <= 1'h0;
      ack_o <= #1 1'h0;
    end else if ((wake_i && !wake_q) || !rst_q) begin
      // New wake or reset release starts the delay
      armed <= (delay_i != 16'h0000);
      cnt <= 0;
    end else if (armed) begin
      cnt <= cnt + 1;
      if (cnt == int'(delay_i)) begin
        ack_o <= #1 1'h1;
      end
      if (cnt == int'(delay_i) + 5) begin
        ack_o <= #1 1'h0;
        armed <= 1'h0;
      end
    end
  end
endmodule

// ==== test/wtw_core_tb.sv ====
// Self-checking testbench of the wake-up timer watchdog core
module wtw_core_tb;
  timeunit 1ns;
  timeprecision 1ns;

  ////////////////////////////////////////////////////////////////////////////
  // Scaled timing: one millisecond is TK cycles
  localparam int TK = 10;
  localparam int T = int'(wtw_pkg::CODE_UNIT_MS) * TK; // Code 1 interval
  localparam int RP = int'(wtw_pkg::RESET_PULSE_MS) * TK; // Reset pulse
  localparam int TOL = 15; // Tick phase plus synchroniser slack

  logic clock_i;
  logic rst_i;
  logic ack_i;
  logic mrst_pin_i;
  logic meas_en_o;
  logic wake_o;
  logic host_reset_low_out_o;
  wtw_pkg::wtw_meas_t meas_i;
  logic [15:0] ack_delay; // Host answer delay in cycles, 0 for none
  int mismatches = 0;
  int tests_run = 0;

  wtw_core #(.TICK_CYC(TK)) DUT (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ack_i(ack_i),
    .mrst_pin_i(mrst_pin_i),
    .meas_i(meas_i),
    .meas_en_o(meas_en_o),
    .wake_o(wake_o),
    .host_reset_low_out_o(host_reset_low_out_o)
  );

  wtw_host_model u_host (
    .clock_i(clock_i),
    .wake_i(wake_o),
    .host_reset_low_i(host_reset_low_out_o),
    .delay_i(ack_delay),
    .ack_o(ack_i)
  );

  // 100 MHz clock
  initial begin
    clock_i = 1'h0;
    forever #5 clock_i = ~clock_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic print_verdict();
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Times carry tick jitter, so a near value counts as exact
  task automatic check_time(input int n, input int exp);
    check(32'((n >= exp - TOL && n <= exp + TOL) ? exp : n), 32'(exp));
  endtask

  // Inputs move 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) begin
      @(posedge clock_i);
      #1;
    end
  endtask

  function automatic logic sig(input int w);
    case (w)
      0: return wake_o;
      1: return host_reset_low_out_o;
      default: return meas_en_o;
    endcase
  endfunction

  // Bounded wait for a level; running out ends the run as a failure
  task automatic wait_sig(input int w, input logic v, input int lim,
                          output int n);
    n = 0;
    while (sig(w) !== v) begin
      if (n >= lim) begin
        mismatches++;
        $display("mismatch at %0t: wait ran out", $time);
        print_verdict();
      end
      step(1);
      n++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  // Power-on, an aborted measurement, then capture of a 100 ms code
  task automatic power_on();
    int n;
    rst_i = 1'h1;
    step(10);
    check(wake_o, 1'h0);
    check(host_reset_low_out_o, 1'h0);
    check(meas_en_o, 1'h0);
    rst_i = 1'h0;
    step(3);
    check(meas_en_o, 1'h1);
    mrst_pin_i = 1'h1;
    wait_sig(2, 1'h0, 10, n);
    step(50);
    check(host_reset_low_out_o, 1'h0);
    mrst_pin_i = 1'h0;
    wait_sig(2, 1'h1, 20, n);
    step(2);
    meas_i = {1'h1, 17'h00001};
    step(1);
    meas_i.valid = 1'h0;
    step(1);
    check(meas_en_o, 1'h0);
    wait_sig(1, 1'h1, RP + 50, n);
    check_time(n, RP);
  endtask

  // Acked intervals: no first wake, fixed period, early end on ack
  task automatic wake_period();
    int n;
    int w;
    wait_sig(0, 1'h1, T + 50, n);
    check_time(n, T);
    wait_sig(0, 1'h0, T, w);
    check_time(w, 25);
    // A late capture pulse must not change the held code
    meas_i = {1'h1, 17'h00005};
    step(1);
    meas_i.valid = 1'h0;
    wait_sig(0, 1'h1, T + 50, n);
    check_time(w + 1 + n, T);
    ack_delay = 16'h012c;
    wait_sig(0, 1'h0, T, w);
    check_time(w, 20 * TK);
    wait_sig(0, 1'h1, T + 50, n);
    check_time(w + n, T);
  endtask

  // Ack too late, then no ack at all
  task automatic missed_ack();
    int n;
    int w;
    ack_delay = 16'h0384;
    wait_sig(1, 1'h0, T + 50, n);
    check_time(n, T);
    check(wake_o, 1'h0);
    ack_delay = 16'h0000;
    wait_sig(1, 1'h1, RP + 50, n);
    check_time(n, RP);
    wait_sig(1, 1'h0, T + 50, w);
    check_time(n + w, RP + T);
    check(wake_o, 1'h0);
    ack_delay = 16'h0014;
    wait_sig(1, 1'h1, RP + 50, n);
  endtask

  // Glitch ignored, then a held press and its release
  task automatic manual_reset();
    int n;
    step(100);
    mrst_pin_i = 1'h1;
    step(15 * TK);
    mrst_pin_i = 1'h0;
    step(30 * TK);
    check(host_reset_low_out_o, 1'h1);
    mrst_pin_i = 1'h1;
    wait_sig(1, 1'h0, 40 * TK, n);
    check_time(n, 20 * TK);
    check(wake_o, 1'h0);
    step(200);
    check(host_reset_low_out_o, 1'h0);
    mrst_pin_i = 1'h0;
    wait_sig(1, 1'h1, RP + 400, n);
    check_time(n, 20 * TK + RP);
    wait_sig(0, 1'h1, T + 50, n);
    check_time(n, T);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_i = 1'h1;
    mrst_pin_i = 1'h0;
    meas_i = '0;
    ack_delay = 16'h0014;
    power_on();
    wake_period();
    missed_ack();
    manual_reset();
    print_verdict();
  end
endmodule
